// ==== srfg_pkg.sv ====
/*
 Shared constants, carrier types and mode encoding for the status read-out
 and fault guard block.
 Assumes a 10 MHz system clock and a host-driven serial clock.
*/
package srfg_pkg;

    localparam int  CLK_PERIOD_NS   = 100;
    localparam real TX_ACTIVE_MAX_MS = 1.5;
    localparam int  TX_ACTIVE_CYCLES =
        int'($floor(TX_ACTIVE_MAX_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int  SPI_MIN_KBPS    = 10;
    localparam int  SPI_MAX_KBPS    = 2000;

    localparam int  STATUS_W        = 32;
    localparam int  FRAME_BITS      = 16;
    localparam int  EXT_BITS        = 32;
    localparam int  CNT_W           = 6;
    localparam logic [CNT_W-1:0] CNT_FRAME = 6'h10;
    localparam logic [CNT_W-1:0] CNT_MAX   = 6'h3f;
    localparam logic [CNT_W-1:0] CNT_ONE   = 6'h01;
    localparam logic [CNT_W-1:0] CNT_EXT   = 6'h20;

    localparam int  BIT_WAKE        = 0;
    localparam int  BIT_MODE        = 1;
    localparam int  BIT_TX_READY    = 2;
    localparam int  BIT_BGE_FB      = 3;
    localparam int  LATCH_LO        = 4;
    localparam int  LATCH_HI        = 10;
    localparam int  LATCH_N         = LATCH_HI - LATCH_LO + 1;
    localparam int  VER_LO          = FRAME_BITS;

    // Latched flag positions, counted from the first latched bit
    localparam int  LF_POWER_ON     = 0;
    localparam int  LF_BUS_ERR      = 1;
    localparam int  LF_THERMAL      = 2;
    localparam int  LF_TX_TIMEOUT   = 3;
    localparam int  LF_MAIN_UV      = 4;
    localparam int  LF_IO_UV        = 5;
    localparam int  LF_FRAME_ERR    = 6;

    localparam int  PIN_N           = 11;
    localparam int  MODE_CHG_CYCLES = 16;
    localparam logic [15:0] VERSION_DEFAULT = 16'h5a3c;

    typedef enum logic [1:0] {
        MODE_POWER_OFF,
        MODE_STANDBY,
        MODE_NORMAL
    } srfg_mode_type;

    typedef struct packed {
        logic                en;
        logic [STATUS_W-1:0] word;
    } srfg_snap_type;

    typedef struct packed {
        logic             err;
        logic [CNT_W-1:0] count;
    } srfg_frame_type;

endpackage : srfg_pkg

// ==== srfg_sync.sv ====
/*
 Two-stage synchroniser for a vector of independent levels.
 Assumes each bit changes slowly compared to the destination clock.
*/
`timescale 1ns/1ps
module srfg_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] q_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_ff <= RST_VAL;
            q_ff    <= RST_VAL;
        end else begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end

    assign q = q_ff;

endmodule : srfg_sync

// ==== srfg_fifo2.sv ====
/*
 Small shifting buffer with valid and ready on both sides.
 Head entry sits in a flip-flop so the output needs no read mux.
*/
`timescale 1ns/1ps
module srfg_fifo2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] nxt_mem [DEPTH];
    logic [DEPTH-1:0] vld_ff;
    logic [DEPTH-1:0] nxt_vld;
    wire              push = in_valid && in_ready;
    wire              pop  = vld_ff[0] && out_ready;

    always_comb begin
        logic found;
        found = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            if (pop) begin
                nxt_vld[i] = (i < DEPTH - 1) ? vld_ff[(i + 1) % DEPTH] : 1'b0;
                nxt_mem[i] = mem_ff[(i + 1) % DEPTH];
            end else begin
                nxt_vld[i] = vld_ff[i];
                nxt_mem[i] = mem_ff[i];
            end
        end
        for (int i = 0; i < DEPTH; i++) begin
            if (push && !found && !nxt_vld[i]) begin
                nxt_vld[i] = 1'b1;
                nxt_mem[i] = in_data;
                found      = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vld_ff <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= '0;
            end
        end else begin
            vld_ff <= nxt_vld;
            mem_ff <= nxt_mem;
        end
    end

    // Full only when the tail holds a word; no push-through when full
    assign in_ready  = !vld_ff[DEPTH-1];
    assign out_valid = vld_ff[0];
    assign out_data  = mem_ff[0];

endmodule : srfg_fifo2

// ==== srfg_top.sv ====
/*
 Fault guard and serial status read-out of a bus driver.
 Assumes analog detectors deliver clean levels, the host is the serial
 master, and the host waits at least 4 CLK periods after chip select
 falls before the first serial clock rising edge.
*/
`timescale 1ns/1ps
module srfg_top
    import srfg_pkg::*;
#(
    parameter int          TX_ACTIVE_CYC = srfg_pkg::TX_ACTIVE_CYCLES,
    parameter int          MODE_CHG_CYC  = srfg_pkg::MODE_CHG_CYCLES,
    parameter logic [15:0] VERSION       = srfg_pkg::VERSION_DEFAULT  // Arbitrary value
) (
    input  wire logic                     CLK,
    input  wire logic                     SYS_RST,
    input  wire logic                     SPI_SCK,
    input  wire logic                     SPI_CS_N,
    output logic                          SPI_SDO_O,
    output logic                          SPI_SDO_OE,
    input  wire logic                     NORMAL_REQ,
    input  wire logic                     TRANSMIT_ENABLE_LOW,
    input  wire logic                     BUS_GUARD_EN,
    input  wire logic                     MAIN_SUPPLY_UV,
    input  wire logic                     IO_SUPPLY_UV,
    input  wire logic                     MAIN_BELOW_POR,
    input  wire logic                     OVER_TEMP,
    input  wire logic                     BUS_ERROR,
    input  wire logic                     REMOTE_WAKE,
    output srfg_pkg::srfg_mode_type       MODE,
    output logic                          TX_ENABLE,
    output logic                          TX_TIMEOUT,
    output logic                          THERMAL_SHUTDOWN,
    output logic                          FRAME_ERROR,
    output logic                          TRACK_MODE,
    output logic [srfg_pkg::LATCH_N-1:0]  STATUS_LATCHED,
    output logic                          FRAME_VALID,
    input  wire logic                     FRAME_READY,
    output srfg_pkg::srfg_frame_type      FRAME_DATA
);
    import srfg_pkg::*;

    localparam int TCNT_W = $clog2(TX_ACTIVE_CYC + 1);
    localparam int MCNT_W = $clog2(MODE_CHG_CYC + 1);
    localparam logic [TCNT_W-1:0] TCNT_LIM = TCNT_W'(TX_ACTIVE_CYC);
    localparam logic [MCNT_W-1:0] MCNT_LIM = MCNT_W'(MODE_CHG_CYC);

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        sat_inc = (v == CNT_MAX) ? v : v + CNT_ONE;
    endfunction : sat_inc

    // Pin synchronisers, chip select idles high
    logic [PIN_N-1:0] pin_s;
    srfg_sync #(
        .WIDTH   (PIN_N),
        .RST_VAL (11'h400)
    ) u_pin_sync (
        .clk (CLK),
        .rst (SYS_RST),
        .d   ({SPI_CS_N, SPI_SCK, NORMAL_REQ, TRANSMIT_ENABLE_LOW, BUS_GUARD_EN,
               MAIN_SUPPLY_UV, IO_SUPPLY_UV, MAIN_BELOW_POR, OVER_TEMP, BUS_ERROR,
               REMOTE_WAKE}),
        .q   (pin_s)
    );
    wire cs_n_s   = pin_s[10];
    wire sck_s    = pin_s[9];
    wire norm_s   = pin_s[8];
    wire transmit_enable_low_l_s = pin_s[7];
    wire bge_s    = pin_s[6];
    wire main_uv  = pin_s[5];
    wire io_uv    = pin_s[4];
    wire por_low  = pin_s[3];
    wire hot_s    = pin_s[2];
    wire bus_err  = pin_s[1];
    wire wake_s   = pin_s[0];

    // Mode selection
    srfg_mode_type mode_ff;
    srfg_mode_type nxt_mode;
    assign nxt_mode = por_low ? MODE_POWER_OFF :
                      (main_uv || io_uv || !norm_s) ? MODE_STANDBY : MODE_NORMAL;
    wire is_normal  = (mode_ff == MODE_NORMAL);

    // Transmit enable timeout
    logic [TCNT_W-1:0] tcnt_ff;
    logic              tout_ff;
    wire               tx_active = is_normal && !transmit_enable_low_l_s;
    wire [TCNT_W-1:0]  nxt_tcnt  = !tx_active ? '0 :
                                   (tcnt_ff == TCNT_LIM) ? tcnt_ff : tcnt_ff + 1'b1;
    wire               nxt_tout  = tx_active && (tout_ff || tcnt_ff == TCNT_LIM);

    // thermal flag held until cool and idle, or until normal mode is left
    logic thermal_ff;
    wire  nxt_thermal = is_normal && (hot_s || (thermal_ff && !transmit_enable_low_l_s));

    logic tx_en_ff;
    wire  tx_ready  = is_normal && !tout_ff && bge_s && !thermal_ff;
    wire  nxt_tx_en = tx_ready && !nxt_tout && !nxt_thermal && !transmit_enable_low_l_s;

    // Power-on flag stays up until normal mode is first reached
    logic pwr_on_ff;

    // Track mode request: chip select low with serial clock high for long
    logic [MCNT_W-1:0] mcnt_ff;
    logic              track_ff;
    wire               trk_req  = !cs_n_s && sck_s && !io_uv && !track_ff;
    wire [MCNT_W-1:0]  nxt_mcnt = trk_req ? mcnt_ff + 1'b1 : '0;
    wire               trk_enter = trk_req && (mcnt_ff == MCNT_LIM - 1'b1);

    wire spi_en = !track_ff && !io_uv && !por_low;

    // Frame boundaries seen in the system domain
    logic cs_prev_ff;
    wire  cs_fall = cs_prev_ff && !cs_n_s;
    wire  cs_rise = !cs_prev_ff && cs_n_s;

    // Snapshot held stable for the link while chip select is low
    srfg_snap_type     snap_ff;
    logic [LATCH_N-1:0] lat_ff;
    logic [STATUS_W-1:0] word;
    always_comb begin
        word                    = '0;
        word[BIT_WAKE]          = wake_s;
        word[BIT_MODE]          = is_normal;
        word[BIT_TX_READY]      = tx_ready;
        word[BIT_BGE_FB]        = is_normal && bge_s;
        word[LATCH_HI:LATCH_LO] = lat_ff;
        word[STATUS_W-1:VER_LO] = VERSION;
    end

    // Link domain: shift out on rising edges
    logic [CNT_W-1:0] rcnt_ff;
    logic             sdo_ff;
    logic             sdo_oe_ff;
    // chip select high holds the output released
    always_ff @(posedge SPI_SCK or posedge SPI_CS_N or posedge SYS_RST) begin
        if (SPI_CS_N || SYS_RST) begin
            rcnt_ff   <= '0;
            sdo_ff    <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end else begin
            // next bit per rising edge, remote wake bit first
            rcnt_ff   <= sat_inc(rcnt_ff);
            sdo_ff    <= (rcnt_ff < CNT_EXT) ? snap_ff.word[rcnt_ff[4:0]] : 1'b0;
            sdo_oe_ff <= snap_ff.en;
        end
    end
    // plain edge clocking, no oversampling, so 2 Mbit/s is no limit
    assign SPI_SDO_O  = sdo_ff;
    assign SPI_SDO_OE = sdo_oe_ff;

    // Link domain: count falling edges; count survives chip select rise
    logic             started_ff;
    logic [CNT_W-1:0] fcnt_ff;
    logic             ftog_ff;
    always_ff @(negedge SPI_SCK or posedge SPI_CS_N or posedge SYS_RST) begin
        if (SPI_CS_N || SYS_RST) begin
            started_ff <= 1'b0;
        end else begin
            started_ff <= 1'b1;
        end
    end
    // falling edges counted only inside a frame
    always_ff @(negedge SPI_SCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            fcnt_ff <= '0;
            ftog_ff <= 1'b0;
        end else if (!SPI_CS_N) begin
            fcnt_ff <= started_ff ? sat_inc(fcnt_ff) : CNT_ONE;
            ftog_ff <= started_ff ? ftog_ff : !ftog_ff;
        end
    end

    // Count and frame toggle are stable long before chip select rise is seen
    logic [CNT_W:0] cnt_s;
    srfg_sync #(
        .WIDTH   (CNT_W + 1),
        .RST_VAL ('0)
    ) u_cnt_sync (
        .clk (CLK),
        .rst (SYS_RST),
        .d   ({ftog_ff, fcnt_ff}),
        .q   (cnt_s)
    );
    logic       tog_seen_ff;
    wire  [CNT_W-1:0] frame_cnt = (cnt_s[CNT_W] != tog_seen_ff) ? cnt_s[CNT_W-1:0] : '0;

    // Frame evaluation
    logic frame_en_ff;
    logic sck_bad_ff;
    logic ferr_ff;
    // wrong count or clock high at an edge
    wire  frame_bad = sck_bad_ff || sck_s || (frame_cnt != CNT_FRAME);

    // Result buffer; the clear is applied only when the result is accepted
    logic           pend_ff;
    srfg_frame_type pend_data_ff;
    logic           fifo_in_rdy;
    wire            push = pend_ff && fifo_in_rdy;
    wire            good_clear = push && !pend_data_ff.err;

    srfg_fifo2 #(
        .WIDTH ($bits(srfg_frame_type)),
        .DEPTH (2)
    ) u_fifo (
        .clk       (CLK),
        .rst       (SYS_RST),
        .in_valid  (pend_ff),
        .in_ready  (fifo_in_rdy),
        .in_data   (pend_data_ff),
        .out_valid (FRAME_VALID),
        .out_ready (FRAME_READY),
        .out_data  (FRAME_DATA)
    );

    // set at frame end wins; clear at frame start or track entry
    wire nxt_ferr = (push && pend_data_ff.err) ||
                    (ferr_ff && !cs_fall && !trk_enter);

    // Latched flag sources
    wire [LATCH_N-1:0] flags = {ferr_ff, io_uv, main_uv, tout_ff, thermal_ff,
                                bus_err && tx_en_ff, pwr_on_ff};
    // set wins; clear only where the flag is low
    wire [LATCH_N-1:0] nxt_lat = flags | (lat_ff & ~{LATCH_N{good_clear}});

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mode_ff      <= MODE_POWER_OFF;
            tcnt_ff      <= '0;
            tout_ff      <= 1'b0;
            thermal_ff   <= 1'b0;
            tx_en_ff     <= 1'b0;
            pwr_on_ff    <= 1'b1;
            mcnt_ff      <= '0;
            track_ff     <= 1'b0;
            cs_prev_ff   <= 1'b1;
            snap_ff      <= '0;
            lat_ff       <= '0;
            tog_seen_ff  <= 1'b0;
            frame_en_ff  <= 1'b0;
            sck_bad_ff   <= 1'b0;
            ferr_ff      <= 1'b0;
            pend_ff      <= 1'b0;
            pend_data_ff <= '0;
        end else begin
            mode_ff      <= nxt_mode;
            tcnt_ff      <= nxt_tcnt;
            tout_ff      <= nxt_tout;
            thermal_ff   <= nxt_thermal;
            tx_en_ff     <= nxt_tx_en;
            pwr_on_ff    <= pwr_on_ff && !is_normal;
            mcnt_ff      <= nxt_mcnt;
            track_ff     <= track_ff || trk_enter;
            cs_prev_ff   <= cs_n_s;
            snap_ff      <= cs_n_s ? srfg_snap_type'{en: spi_en, word: word} : snap_ff;
            lat_ff       <= nxt_lat;
            if (cs_fall) begin
                frame_en_ff <= snap_ff.en;
                sck_bad_ff  <= sck_s;
            end
            ferr_ff      <= nxt_ferr;
            if (cs_rise) begin
                tog_seen_ff <= cnt_s[CNT_W];
            end
            // A frame ending while an older result still waits is dropped
            if (cs_rise && frame_en_ff && (!pend_ff || push)) begin
                pend_ff      <= 1'b1;
                pend_data_ff <= '{err: frame_bad, count: frame_cnt};
            end else if (push) begin
                pend_ff      <= 1'b0;
            end
        end
    end

    assign MODE             = mode_ff;
    assign TX_ENABLE        = tx_en_ff;
    assign TX_TIMEOUT       = tout_ff;
    assign THERMAL_SHUTDOWN = thermal_ff;
    assign FRAME_ERROR      = ferr_ff;
    assign TRACK_MODE       = track_ff;
    assign STATUS_LATCHED   = lat_ff;

endmodule : srfg_top

// ==== srfg_checker.sv ====
/*
 Port checks of the read-out and fault guard block.
 Assumes it is bound to srfg_top, with TX_ACTIVE_CYC handed on.
*/
`timescale 1ns/1ps
module srfg_checker
    import srfg_pkg::*;
#(
    parameter int TX_ACTIVE_CYC = srfg_pkg::TX_ACTIVE_CYCLES
) (
    input wire logic                         CLK,
    input wire logic                         SYS_RST,
    input wire logic                         SPI_CS_N,
    input wire logic                         SPI_SDO_OE,
    input wire logic                         TRANSMIT_ENABLE_LOW,
    input wire logic                         MAIN_SUPPLY_UV,
    input wire logic                         IO_SUPPLY_UV,
    input wire logic                         MAIN_BELOW_POR,
    input wire logic                         OVER_TEMP,
    input wire srfg_pkg::srfg_mode_type      MODE,
    input wire logic                         TX_ENABLE,
    input wire logic                         TX_TIMEOUT,
    input wire logic                         FRAME_ERROR,
    input wire logic                         TRACK_MODE,
    input wire logic [srfg_pkg::LATCH_N-1:0] STATUS_LATCHED,
    input wire logic                         FRAME_VALID,
    input wire srfg_pkg::srfg_frame_type     FRAME_DATA
);
    default clocking dcb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    logic [31:0] low_cnt_ff;
    logic [31:0] nxt_low_cnt;
    logic [2:0]  dis_cnt_ff;
    logic [2:0]  nxt_dis_cnt;
    logic        blocked_ff;
    logic        nxt_blocked;
    logic        port_off;

    assign nxt_low_cnt = (MODE == MODE_NORMAL && !TRANSMIT_ENABLE_LOW) ? low_cnt_ff + 32'h1 : 32'h0;
    assign port_off    = IO_SUPPLY_UV || MAIN_BELOW_POR || TRACK_MODE;
    assign nxt_dis_cnt = !port_off ? 3'h0 : (dis_cnt_ff == 3'h4) ? 3'h4 : dis_cnt_ff + 3'h1;
    // A disable must settle before select falls to be sure of reaching the link side
    assign nxt_blocked = SPI_CS_N ? (dis_cnt_ff == 3'h4) : blocked_ff;

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            low_cnt_ff <= 32'h0;
            dis_cnt_ff <= 3'h0;
            blocked_ff <= 1'b0;
        end else begin
            low_cnt_ff <= nxt_low_cnt;
            dis_cnt_ff <= nxt_dis_cnt;
            blocked_ff <= nxt_blocked;
        end
    end

    property p_cs_idle;
        SPI_CS_N |-> !SPI_SDO_OE;
    endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("output driven while deselected");
    property p_uv;
        (MAIN_SUPPLY_UV || IO_SUPPLY_UV)[*5] |-> !TX_ENABLE && MODE != MODE_NORMAL;
    endproperty
    a_uv: assert property (p_uv) else $error("no standby under undervoltage");
    property p_tmo;
        low_cnt_ff > TX_ACTIVE_CYC + 6 |-> TX_TIMEOUT && !TX_ENABLE;
    endproperty
    a_tmo: assert property (p_tmo) else $error("transmit timeout missed");
    property p_tmo_clear;
        TRANSMIT_ENABLE_LOW[*4] |-> !TX_TIMEOUT;
    endproperty
    a_tmo_clear: assert property (p_tmo_clear) else $error("timeout kept with enable high");
    property p_hot;
        (OVER_TEMP && MODE == MODE_NORMAL)[*5] |-> !TX_ENABLE;
    endproperty
    a_hot: assert property (p_hot) else $error("transmitter on while hot");
    property p_frame_cnt;
        FRAME_VALID && FRAME_DATA.count != CNT_FRAME |-> FRAME_DATA.err;
    endproperty
    a_frame_cnt: assert property (p_frame_cnt) else $error("bad length not flagged");
    property p_clear_when;
        |($past(STATUS_LATCHED) & ~STATUS_LATCHED) |-> $past(SPI_CS_N, 2) && !FRAME_ERROR;
    endproperty
    a_clear_when: assert property (p_clear_when) else $error("latched bit cleared early");
    property p_latch_set;
        TX_TIMEOUT |-> ##[1:2] STATUS_LATCHED[LF_TX_TIMEOUT];
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("timeout not latched");
    property p_port_off;
        !SPI_CS_N && blocked_ff |-> !SPI_SDO_OE;
    endproperty
    a_port_off: assert property (p_port_off) else $error("disabled port drove data");
    property p_start_latched;
        $past(SYS_RST) |-> !TRACK_MODE;
    endproperty
    a_start_latched: assert property (p_start_latched) else $error("track mode at start");
endmodule : srfg_checker

bind srfg_top srfg_checker #(.TX_ACTIVE_CYC(TX_ACTIVE_CYC)) chk_u (
    .CLK(CLK), .SYS_RST(SYS_RST), .SPI_CS_N(SPI_CS_N), .SPI_SDO_OE(SPI_SDO_OE),
    .TRANSMIT_ENABLE_LOW(TRANSMIT_ENABLE_LOW), .MAIN_SUPPLY_UV(MAIN_SUPPLY_UV),
    .IO_SUPPLY_UV(IO_SUPPLY_UV), .MAIN_BELOW_POR(MAIN_BELOW_POR), .OVER_TEMP(OVER_TEMP),
    .MODE(MODE), .TX_ENABLE(TX_ENABLE), .TX_TIMEOUT(TX_TIMEOUT), .FRAME_ERROR(FRAME_ERROR),
    .TRACK_MODE(TRACK_MODE), .STATUS_LATCHED(STATUS_LATCHED), .FRAME_VALID(FRAME_VALID),
    .FRAME_DATA(FRAME_DATA)
);

// ==== srfg_host_model.sv ====
/*
 Host side of the serial read-out: drives select and serial clock.
 Assumes the bench starts frames through the frame task.
*/
`timescale 1ns/1ps
module srfg_host_model (
    output logic      sck,
    output logic      cs_n,
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    initial begin
        sck  = 1'b0;
        cs_n = 1'b1;
    end

    // rate in range, clock low at select rise; hi_cs sets the clock level at select fall
    task automatic frame(input int n, input int half, input bit hi_cs,
                         output logic [31:0] rx, output int n_oe);
        realtime h;
        // Odd fractions keep edges off the system clock edges
        h = half + 0.013;
        rx = 'x;
        n_oe = 0;
        sck = hi_cs;
        #0.3 cs_n = 1'b0;
        #(h) sck = 1'b0;
        #(513.3);
        for (int k = 0; k < n; k++) begin
            #(h) sck = 1'b1;
            #(h);
            if (k < 32) rx[k] = sdo_oe ? sdo : 1'bx;
            n_oe += int'(sdo_oe);
            sck = 1'b0;
        end
        #(h) cs_n = 1'b1;
        #(513.3);
    endtask : frame
endmodule : srfg_host_model

// ==== testbench.sv ====
/*
 Self-checking bench of srfg_top with a host model on the link.
 Assumes a 10 MHz clock; the timeout count is shortened to 40.
*/
`timescale 1ns/1ps
module testbench;
    import srfg_pkg::*;
    localparam logic [15:0] VER = 16'h1234;  // Arbitrary value
    logic clk, rst, sck, cs_n, sdo, sdo_oe, nreq, transmit_enable_low_n, bge, main_uv, io_uv;
    logic below_por, hot, bus_err, wake, tx_en, tmo, thermal, ferr, track, fvalid, fready;
    srfg_mode_type      mode;
    srfg_frame_type     fdata;
    logic [LATCH_N-1:0] latched;
    logic [31:0]        rx;
    int n_oe, n_mismatch, comparisons, seed, n;

    srfg_top #(.TX_ACTIVE_CYC(40), .VERSION(VER)) dut_u (
        .CLK(clk), .SYS_RST(rst), .SPI_SCK(sck), .SPI_CS_N(cs_n), .SPI_SDO_O(sdo),
        .SPI_SDO_OE(sdo_oe), .NORMAL_REQ(nreq), .TRANSMIT_ENABLE_LOW(transmit_enable_low_n),
        .BUS_GUARD_EN(bge), .MAIN_SUPPLY_UV(main_uv), .IO_SUPPLY_UV(io_uv),
        .MAIN_BELOW_POR(below_por), .OVER_TEMP(hot), .BUS_ERROR(bus_err),
        .REMOTE_WAKE(wake), .MODE(mode), .TX_ENABLE(tx_en), .TX_TIMEOUT(tmo),
        .THERMAL_SHUTDOWN(thermal), .FRAME_ERROR(ferr), .TRACK_MODE(track),
        .STATUS_LATCHED(latched), .FRAME_VALID(fvalid), .FRAME_READY(fready),
        .FRAME_DATA(fdata)
    );
    srfg_host_model host_u (.sck(sck), .cs_n(cs_n), .sdo(sdo), .sdo_oe(sdo_oe));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [15:0] exp_word(logic w, logic [6:0] lat, logic nrm);
        return {5'h0, lat, nrm, nrm, nrm, w};
    endfunction : exp_word

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc

    task automatic rd(input int len, input bit hi);
        wake = 1'($random(seed));
        cyc(4);
        // Half periods stay short so a high-clock start never reaches track mode
        host_u.frame(len, 250 + int'($unsigned($random(seed)) % 1000), hi, rx, n_oe);
        @(negedge clk);
    endtask : rd

    task automatic result(input logic err, input logic [5:0] cnt);
        int i;
        i = 0;
        while (fvalid !== 1'b1 && i < 40) begin
            @(negedge clk);
            i++;
        end
        chk({fvalid, fdata}, {1'b1, err, cnt}, "frame result");
        fready = 1'b1;
        @(negedge clk);
        fready = 1'b0;
    endtask : result

    task automatic none();
        cyc(20);
        chk(fvalid, 1'b0, "no frame result");
    endtask : none

    task automatic done(input string s);
        $display("test %s done at %0t", s, $time);
    endtask : done

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #5000000;
        n_mismatch++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        {rst, nreq, bge, main_uv, io_uv, below_por, hot, bus_err, wake, fready} = 10'h200;
        transmit_enable_low_n = 1'b1;
        seed = 32'h5988d9b2;
        n_mismatch = 0;
        comparisons = 0;
        cyc(6);
        rst = 1'b0;
        cyc(6);
        rd(16, 1'b0);
        chk(rx[15:0], exp_word(wake, 7'h01, 1'b0), "standby word");
        result(1'b0, 6'h10);
        chk(latched, 7'h01, "power-on kept");
        done("standby");
        {nreq, bge} = 2'b11;
        cyc(8);
        rd(32, 1'b0);
        chk(rx, {VER, exp_word(wake, 7'h01, 1'b1)}, "extended word");
        result(1'b1, 6'h20);
        chk(latched, 7'h41, "frame error latched");
        rd(16, 1'b0);
        chk(rx[15:0], exp_word(wake, 7'h41, 1'b1), "normal word");
        result(1'b0, 6'h10);
        chk({ferr, latched}, 8'h00, "clean frame clears");
        done("extended");
        transmit_enable_low_n = 1'b0;
        cyc(5);
        chk(tx_en, 1'b1, "transmit on");
        bus_err = 1'b1;
        cyc(3);
        bus_err = 1'b0;
        cyc(45);
        chk({tmo, tx_en}, 2'b10, "timeout");
        transmit_enable_low_n = 1'b1;
        cyc(4);
        chk({tmo, tx_en}, 2'b00, "timeout left");
        transmit_enable_low_n = 1'b0;
        hot = 1'b1;
        cyc(5);
        chk({thermal, tx_en}, 2'b10, "thermal");
        {hot, transmit_enable_low_n} = 2'b01;
        cyc(5);
        chk(thermal, 1'b0, "thermal left");
        rd(16, 1'b0);
        chk(rx[15:0], exp_word(wake, 7'h0e, 1'b1), "fault word");
        result(1'b0, 6'h10);
        chk(latched, 7'h00, "faults cleared");
        done("faults");
        main_uv = 1'b1;
        cyc(6);
        chk({mode, tx_en}, {MODE_STANDBY, 1'b0}, "main undervoltage");
        rd(16, 1'b0);
        chk(rx[15:0], exp_word(wake, 7'h10, 1'b0), "undervoltage word");
        result(1'b0, 6'h10);
        chk(latched, 7'h10, "flag keeps bit");
        {main_uv, io_uv} = 2'b01;
        cyc(6);
        chk(mode, MODE_STANDBY, "io undervoltage");
        rd(16, 1'b0);
        chk(n_oe, 0, "port off io");
        none();
        {io_uv, below_por} = 2'b01;
        cyc(6);
        chk(mode, MODE_POWER_OFF, "power off");
        rd(16, 1'b0);
        chk(n_oe, 0, "port off por");
        none();
        below_por = 1'b0;
        cyc(6);
        done("supplies");
        rd(15, 1'b1);
        result(1'b1, 6'h10);
        chk(track, 1'b0, "latched mode kept");
        rd(15, 1'b0);
        rd(17, 1'b0);
        rd(16, 1'b0);
        result(1'b1, 6'h0f);
        result(1'b1, 6'h11);
        result(1'b0, 6'h10);
        none();
        chk(latched, 7'h00, "late clear");
        done("buffer");
        repeat (6) begin
            n = int'($unsigned($random(seed)) % 34);
            rd(n, 1'b0);
            result(n != 16, 6'(n));
        end
        done("random");
        end_of_test();
    end
endmodule : testbench
